// ### common/dct_pkg.sv
// Overview of operation
// (R1) A 400 ns qualification timer is counted from the system clock.
// (R2) Reset starts in bus free; B busy/select pass to A; free after 400 ns.
// (R3) Arbitration drives busy both ways; select on either side enters select 1; timeout clears.
// (R4) Select 1 holds the winner-side latch from entry and keeps the reconnect latch transparent.
// (R5) A B-side winner talking to the B side keeps select 1 throughout.
// (R6) B-only transfer ending with bus free moves select 1 to arbitration.
// (R7) Select 2 only for opposite-side initiator and target; reconnect latch closes.
// (R8) Reconnect latch one means reselection, zero means selection.
// (R9) Winner on B in selection: A drives ACK/ATN/SEL, B drives target group.
// (R10) Winner latch zero reverses every control-line direction except RST.
// (R11) Data drive force tells data transceivers to ignore direction and negate.
// (R12) Data direction output follows the I/O bus signal.
// (R13) Selection moves select 2 straight to transfer with equal directions.
// (R14) Reselection waits for SEL release, then transfer reverses BSY direction.
// (R15) Select 2 keeps data drive force low; transfer asserts it.
// (R16) Transfer holds through all phases, leaves to arbitration on bus free.
// (R17) Drivers stay on after release until the 400 ns state change.
// (R18) Timeout pin driven high in reset and idle; timing starts by releasing it.
// (R19) Low threshold re-enables driver; timeout declared once pin is high again.
// (R20) Bus reset on one side is driven to the other; origin latched.
// (R21) Origin release drops the driver; direction held until both sides clear.
// (R22) Filtered clear resets the controller but not the bus reset latch.
// (R23) Bus inputs pass through synchronizers; transitions evaluated every clock.
// (R24) The 400 ns timer restarts whenever B-side busy or select reasserts.
package dct_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BUS_FREE_NS = 400;
  localparam int BUS_FREE_CYC =
    (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // R1

  // ==========================================================================
  // Register map
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_SOFT_CLR_BIT = 0;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_WINNER_BIT = 4;
  localparam int ST_RECONN_BIT = 5;
  localparam int ST_RSTDIR_LSB = 6;
  localparam int ST_TMO_LSB = 8;
  localparam int ST_FORCE_BIT = 10;
  localparam int ST_FREE_BIT = 11;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_BUS_FREE = 3'b000,
    ST_ARB = 3'b001,
    ST_SEL1 = 3'b010,
    ST_SEL2 = 3'b011,
    ST_XFER = 3'b100
  } dct_state_e;

  typedef enum logic [1:0] {
    TMO_IDLE = 2'b00,
    TMO_RUN = 2'b01,
    TMO_RECOVER = 2'b10
  } dct_tmo_e;

  typedef enum logic [1:0] {
    RDIR_NONE = 2'b00,
    RDIR_FROM_A = 2'b01,
    RDIR_FROM_B = 2'b10
  } dct_rstdir_e;

  // One bit per SCSI control line, asserted level is 1.
  typedef struct packed {
    logic bsy;
    logic sel;
    logic rst;
    logic atn;
    logic ack;
    logic req;
    logic msg;
    logic cd;
    logic io;
  } dct_ctl_s;

endpackage : dct_pkg

// ### design/dct_idle_timer.sv
module dct_idle_timer
  import dct_pkg::*;
#(
  parameter int CYCLES = BUS_FREE_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic idle,
  output logic qualified
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic qualified_nxt;

  // Any reassertion throws away the partial interval.
  assign count_nxt = !idle ? '0 :
                     (count_r == LAST) ? count_r : count_r + 1'b1; // R24
  assign qualified_nxt = idle && (count_r == LAST); // R1

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      count_r <= '0;
      qualified <= 1'b0;
    end else begin
      count_r <= count_nxt;
      qualified <= qualified_nxt;
    end
  end

endmodule : dct_idle_timer

// ### design/dct_top.sv
module dct_top
  import dct_pkg::*;
#(
  parameter int FREE_CYCLES = BUS_FREE_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dct_ctl_s aSideIn,
  output dct_ctl_s aSideOut,
  output dct_ctl_s aSideOeN,
  input wire dct_ctl_s bSideIn,
  output dct_ctl_s bSideOut,
  output dct_ctl_s bSideOeN,
  input wire logic timeoutIn,
  output logic timeoutOut,
  output logic timeoutOeN,
  input wire logic filteredClearIn,
  output logic dataDriveForce,
  output logic dataDirectionOut
);

  // ==========================================================================
  // Input synchronisers
  dct_ctl_s aMeta_r;
  dct_ctl_s aSync_r;
  dct_ctl_s bMeta_r;
  dct_ctl_s bSync_r;
  logic tmoMeta_r;
  logic tmoSync_r;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      aMeta_r <= '0;
      aSync_r <= '0;
      bMeta_r <= '0;
      bSync_r <= '0;
      tmoMeta_r <= 1'b1;
      tmoSync_r <= 1'b1;
    end else begin
      aMeta_r <= aSideIn; // R23
      aSync_r <= aMeta_r;
      bMeta_r <= bSideIn; // R23
      bSync_r <= bMeta_r;
      tmoMeta_r <= timeoutIn;
      tmoSync_r <= tmoMeta_r;
    end
  end

  // ==========================================================================
  // Register file
  logic [31:0] ctrl_r;
  logic accessPhase;
  logic accessDone;
  logic hitCtrl;
  logic hitStatus;
  logic [31:0] statusWord;
  logic [31:0] readWord;
  logic softClear;

  assign accessPhase = psel && penable;
  assign accessDone = accessPhase && pready;
  assign hitCtrl = (paddr == ADDR_CTRL);
  assign hitStatus = (paddr == ADDR_STATUS);
  assign readWord = hitCtrl ? ctrl_r : hitStatus ? statusWord : 32'h0000_0000;
  assign softClear = ctrl_r[CTRL_SOFT_CLR_BIT];

  // The slave inserts one wait state so that read data is always registered.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctrl_r <= CTRL_RESET;
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= accessPhase && !pready;
      prdata <= (accessPhase && !pready && !pwrite) ? readWord : 32'h0000_0000;
      pslverr <= accessPhase && !pready && !(hitCtrl || hitStatus);
      if (accessDone && pwrite && hitCtrl) begin
        ctrl_r <= pwdata;
      end
    end
  end

  // ==========================================================================
  // Bus free qualification
  logic bIdle;
  logic busFree;

  assign bIdle = !bSync_r.bsy && !bSync_r.sel;

  dct_idle_timer #(
    .CYCLES(FREE_CYCLES)
  ) u_free_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .idle(bIdle),
    .qualified(busFree)
  );

  // ==========================================================================
  // Controller state, latches and arbitration timeout
  dct_state_e state_r;
  dct_state_e state_nxt;
  dct_tmo_e tmo_r;
  dct_tmo_e tmo_nxt;
  logic winner_r;
  logic winner_nxt;
  logic reconn_r;
  logic reconn_nxt;
  logic timeoutEvent;
  logic ctlClear;
  logic ioLevel;

  assign ctlClear = filteredClearIn || softClear; // R22
  assign ioLevel = aSync_r.io || bSync_r.io;
  assign timeoutEvent = (tmo_r == TMO_RECOVER) && tmoSync_r; // R19

  always_comb begin
    tmo_nxt = TMO_IDLE;
    if (state_r == ST_ARB) begin
      case (tmo_r)
        TMO_IDLE: tmo_nxt = TMO_RUN; // R18
        TMO_RUN: tmo_nxt = tmoSync_r ? TMO_RUN : TMO_RECOVER; // R19
        TMO_RECOVER: tmo_nxt = tmoSync_r ? TMO_IDLE : TMO_RECOVER;
        default: tmo_nxt = TMO_IDLE;
      endcase
    end
  end

  always_comb begin
    state_nxt = state_r;
    winner_nxt = winner_r;
    reconn_nxt = reconn_r;
    case (state_r)
      ST_BUS_FREE: begin
        if (busFree) begin
          state_nxt = ST_ARB; // R2
        end
      end
      ST_ARB: begin
        if (aSync_r.sel || bSync_r.sel) begin
          state_nxt = ST_SEL1; // R3
          // Nobody drives select in arbitration, so this is a clean sample.
          winner_nxt = bSync_r.sel; // R4
        end else if (timeoutEvent) begin
          state_nxt = ST_BUS_FREE; // R3
        end
      end
      ST_SEL1: begin
        // Our own select drive onto B echoes back through the line, so the
        // winner is held from entry instead of flipping on that echo.
        winner_nxt = winner_r; // R4
        reconn_nxt = ioLevel; // R4
        // A B-side winner stays here while the object is also on B.
        if (winner_r && aSync_r.bsy && !bSync_r.bsy) begin
          state_nxt = ST_SEL2; // R7
        end else if (!winner_r && bSync_r.bsy && !aSync_r.bsy) begin
          state_nxt = ST_SEL2; // R7
        end else if (busFree) begin
          state_nxt = ST_ARB; // R6
        end else begin
          state_nxt = ST_SEL1; // R5
        end
      end
      ST_SEL2: begin
        if (!reconn_r) begin
          state_nxt = ST_XFER; // R13
        end else if (!aSync_r.sel && !bSync_r.sel) begin
          state_nxt = ST_XFER; // R14
        end
      end
      ST_XFER: begin
        if (busFree) begin
          state_nxt = ST_ARB; // R16
        end
      end
      default: state_nxt = ST_BUS_FREE;
    endcase
    if (ctlClear) begin
      state_nxt = ST_BUS_FREE; // R22
      winner_nxt = 1'b0;
      reconn_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_r <= ST_BUS_FREE; // R2
      tmo_r <= TMO_IDLE;
      winner_r <= 1'b0;
      reconn_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tmo_r <= ctlClear ? TMO_IDLE : tmo_nxt;
      winner_r <= winner_nxt;
      reconn_r <= reconn_nxt;
    end
  end

  // ==========================================================================
  // Bus reset direction latch, untouched by the controller clear
  dct_rstdir_e rstDir_r;
  dct_rstdir_e rstDir_nxt;

  always_comb begin
    rstDir_nxt = rstDir_r;
    case (rstDir_r)
      RDIR_NONE: begin
        if (aSync_r.rst) begin
          rstDir_nxt = RDIR_FROM_A; // R20
        end else if (bSync_r.rst) begin
          rstDir_nxt = RDIR_FROM_B; // R20
        end
      end
      RDIR_FROM_A, RDIR_FROM_B: begin
        if (!aSync_r.rst && !bSync_r.rst) begin
          rstDir_nxt = RDIR_NONE; // R21
        end
      end
      default: rstDir_nxt = RDIR_NONE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rstDir_r <= RDIR_NONE;
    end else begin
      rstDir_r <= rstDir_nxt;
    end
  end

  // ==========================================================================
  // Driver directions
  dct_ctl_s enA;
  dct_ctl_s enB;
  dct_ctl_s valA;
  dct_ctl_s valB;
  logic initOnB;
  logic bsyOnB;
  logic inConnect;
  logic busyEither;

  // Selection: initiator is the winner; reselection: it is the other side.
  assign initOnB = winner_r ^ reconn_r; // R8
  // During reselection select 2 the initiator's BSY goes to the target side.
  assign bsyOnB = initOnB ^ ((state_nxt == ST_SEL2) && reconn_r); // R14
  assign inConnect = (state_nxt == ST_SEL2) || (state_nxt == ST_XFER);
  assign busyEither = aSync_r.bsy || bSync_r.bsy;

  always_comb begin
    enA = '0;
    enB = '0;
    valA = bSync_r;
    valB = aSync_r;
    // Directions follow the next state, so drivers drop at the state change.
    case (state_nxt)
      ST_BUS_FREE: begin
        enA.bsy = 1'b1; // R2
        enA.sel = 1'b1;
      end
      ST_ARB: begin
        enA.bsy = 1'b1; // R3
        enB.bsy = 1'b1;
        valA.bsy = busyEither;
        valB.bsy = busyEither;
      end
      ST_SEL1: begin
        if (winner_nxt) begin
          enA = '1; // R4
        end else begin
          enB = '1;
        end
        enA.bsy = 1'b0;
        enB.bsy = 1'b0;
      end
      default: begin
        if (inConnect) begin
          // Target group toward the initiator side, initiator group away.
          enB.req = initOnB; // R9
          enB.msg = initOnB;
          enB.cd = initOnB;
          enB.io = initOnB;
          enA.ack = initOnB;
          enA.atn = initOnB;
          enA.sel = initOnB;
          enA.req = !initOnB; // R10
          enA.msg = !initOnB;
          enA.cd = !initOnB;
          enA.io = !initOnB;
          enB.ack = !initOnB;
          enB.atn = !initOnB;
          enB.sel = !initOnB;
          enB.bsy = bsyOnB; // R17
          enA.bsy = !bsyOnB;
        end
      end
    endcase
    enA.rst = (rstDir_nxt == RDIR_FROM_B) && bSync_r.rst; // R21
    enB.rst = (rstDir_nxt == RDIR_FROM_A) && aSync_r.rst; // R21
    valA.rst = 1'b1; // R20
    valB.rst = 1'b1;
  end

  // ==========================================================================
  // Registered pin drive
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      aSideOut <= '0;
      bSideOut <= '0;
      aSideOeN <= '1;
      bSideOeN <= '1;
      timeoutOut <= 1'b1;
      timeoutOeN <= 1'b0; // R18
      dataDriveForce <= 1'b0;
      dataDirectionOut <= 1'b0;
    end else begin
      aSideOut <= valA;
      bSideOut <= valB;
      aSideOeN <= ~enA;
      bSideOeN <= ~enB;
      timeoutOut <= 1'b1;
      timeoutOeN <= (tmo_nxt == TMO_RUN) && !ctlClear; // R18
      dataDriveForce <= (state_nxt == ST_XFER); // R11 R15
      dataDirectionOut <= ioLevel; // R12
    end
  end

  // ==========================================================================
  // Status word
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[ST_STATE_LSB +: 3] = state_r;
    statusWord[ST_WINNER_BIT] = winner_r;
    statusWord[ST_RECONN_BIT] = reconn_r;
    statusWord[ST_RSTDIR_LSB +: 2] = rstDir_r;
    statusWord[ST_TMO_LSB +: 2] = tmo_r;
    statusWord[ST_FORCE_BIT] = dataDriveForce;
    statusWord[ST_FREE_BIT] = busFree;
  end

endmodule : dct_top

// ### testbench/dct_assertions.sv
module dct_assertions
  import dct_pkg::*;
#(
  parameter int FREE_CYCLES = BUS_FREE_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire dct_ctl_s aSideIn,
  input wire dct_ctl_s aSideOeN,
  input wire dct_ctl_s bSideIn,
  input wire dct_ctl_s bSideOut,
  input wire dct_ctl_s bSideOeN,
  input wire logic timeoutIn,
  input wire logic timeoutOeN,
  input wire logic filteredClearIn,
  input wire logic dataDriveForce,
  input wire logic dataDirectionOut
);
  timeunit 1ns;
  timeprecision 1ps;

  // ====================
  // Helper logic
  int idleCnt;
  logic [5:0] clrHist;

  always_ff @(posedge clk_sys) begin
    if (!resetn || bSideIn.bsy || bSideIn.sel) idleCnt <= 0;
    else if (idleCnt < 1000) idleCnt <= idleCnt + 1;
  end

  // Clears and register writes may legally drop the force; mask them.
  always_ff @(posedge clk_sys) begin
    clrHist <= {clrHist[4:0], filteredClearIn | (psel & pwrite)};
  end

  // ====================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence ioHi;
    (aSideIn.io || bSideIn.io) [*4];
  endsequence
  sequence busBusy;
    (bSideIn.bsy || bSideIn.sel) [*4];
  endsequence
  sequence rstFromA;
    (!aSideIn.rst && !bSideIn.rst) [*2] ##1 aSideIn.rst [*4];
  endsequence

  tmo_reset_a: assert property (disable iff (1'b0)
    !resetn ##1 !resetn |-> !timeoutOeN) else $error("pin free in reset");
  tmo_rearm_a: assert property (
    timeoutOeN ##1 !timeoutIn [*4] |-> !timeoutOeN)
    else $error("timeout driver not back on");
  rst_fwd_a: assert property (
    rstFromA |-> !bSideOeN.rst && bSideOut.rst) else $error("reset not sent");
  rst_rel_a: assert property (
    !bSideOeN.rst ##1 !aSideIn.rst [*4] |-> bSideOeN.rst)
    else $error("reset driver stuck");
  rst_excl_a: assert property (
    !(!aSideOeN.rst && !bSideOeN.rst)) else $error("reset driven both ways");
  busy_both_a: assert property (
    aSideIn.bsy [*4] ##0 (!aSideOeN.bsy && !bSideOeN.bsy) |-> bSideOut.bsy)
    else $error("busy not mirrored");
  xfer_hold_a: assert property (
    busBusy ##0 (dataDriveForce && clrHist == 6'h00) |=> dataDriveForce)
    else $error("transfer left while busy");
  free_wait_a: assert property (
    $fell(dataDriveForce) && clrHist == 6'h00 |-> idleCnt >= FREE_CYCLES)
    else $error("drivers off too early");
  dir_copy_a: assert property (
    ioHi |-> dataDirectionOut) else $error("direction not from io");
  rdy_pulse_a: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("ready timing wrong");
endmodule : dct_assertions

bind dct_top dct_assertions #(.FREE_CYCLES(FREE_CYCLES)) u_dct_assertions (.*);

// ### testbench/dct_scsi_model.sv
module dct_scsi_model
  import dct_pkg::*;
#(
  parameter int RC_CYCLES = 60
) (
  input wire logic clk_sys,
  input wire dct_ctl_s aDev,
  input wire dct_ctl_s bDev,
  input wire dct_ctl_s aSideOut,
  input wire dct_ctl_s aSideOeN,
  input wire dct_ctl_s bSideOut,
  input wire dct_ctl_s bSideOeN,
  input wire logic timeoutOut,
  input wire logic timeoutOeN,
  output dct_ctl_s aSideIn,
  output dct_ctl_s bSideIn,
  output logic timeoutIn
);
  timeunit 1ns;
  timeprecision 1ps;

  // ====================
  // Bus wires
  int charge = 0;

  // Terminated lines read asserted only while some party pulls them.
  assign aSideIn = dct_ctl_s'(aDev | (aSideOut & ~aSideOeN));
  assign bSideIn = dct_ctl_s'(bDev | (bSideOut & ~bSideOeN));
  // Slow charge when released, fast dump when driven, so recovery is short.
  assign timeoutIn = charge < RC_CYCLES;

  always @(posedge clk_sys) begin
    if (timeoutOeN) charge <= charge + 1;
    else if (timeoutOut) charge <= (charge > 8) ? charge - 8 : 0;
  end
endmodule : dct_scsi_model

// ### testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dct_pkg::*;

  // ====================
  // Signals
  localparam int FREE = 4;
  logic clk_sys = 1'h0, resetn = 1'h0, filteredClearIn = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, savedBsy, timeoutIn, timeoutOut, timeoutOeN;
  logic dataDriveForce, dataDirectionOut;
  dct_ctl_s aDev = '0, bDev = '0;
  dct_ctl_s aSideIn, aSideOut, aSideOeN, bSideIn, bSideOut, bSideOeN;
  int n_mismatch = 0, samples_checked = 0;

  dct_top #(.FREE_CYCLES(FREE)) u_dct_top (.*);
  dct_scsi_model u_dct_scsi_model (.*);

  initial forever #5 clk_sys = ~clk_sys;

  // ====================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    repeat (20) begin
      @(posedge clk_sys);
      if (pready === 1'h1) break;
    end
    if (pready !== 1'h1) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic waitst(input logic [2:0] s);
    for (int i = 0; i < 80; i++) begin
      apb(1'h0, ADDR_STATUS, 32'h0);
      if (rd[2:0] === s) break;
    end
    chk(rd[2:0], s);
    cyc(2);
  endtask : waitst

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // ====================
  // Tests
  initial begin
    repeat (12) @(posedge clk_sys);
    chk(timeoutOeN, 1'h0);
    chk(timeoutOut, 1'h1);
    resetn <= 1'h1;
    apb(1'h0, 12'hffc, 32'h0);
    chk(err, 1'h1);
    apb(1'h1, ADDR_CTRL, 32'h1);
    apb(1'h0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h1);
    cyc(20);
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk(rd[2:0], ST_BUS_FREE);
    apb(1'h1, ADDR_CTRL, 32'h0);
    waitst(ST_ARB);
    chk({aSideOeN.bsy, bSideOeN.bsy}, 2'h0);
    bDev.bsy <= 1'h1;
    cyc(5);
    chk(aSideOut.bsy, 1'h1);
    bDev.sel <= 1'h1;
    waitst(ST_SEL1);
    chk(rd[ST_WINNER_BIT], 1'h1);
    aDev.bsy <= 1'h1;
    bDev.bsy <= 1'h0;
    waitst(ST_XFER);
    chk(rd[ST_RECONN_BIT], 1'h0);
    chk(dataDriveForce, 1'h1);
    chk(aSideOeN, 9'h14f);
    chk(bSideOeN, 9'h0f0);
    aDev.io <= 1'h1;
    cyc(5);
    chk(dataDirectionOut, 1'h1);
    chk(bSideOut.io, 1'h1);
    aDev <= '0;
    bDev <= '0;
    cyc(3);
    chk(dataDriveForce, 1'h1);
    waitst(ST_ARB);
    chk(dataDriveForce, 1'h0);
    chk(bSideOeN.req, 1'h1);
    // Busy held on B keeps the controller parked after the timeout.
    bDev.bsy <= 1'h1;
    waitst(ST_BUS_FREE);
    bDev.bsy <= 1'h0;
    waitst(ST_ARB);
    aDev.bsy <= 1'h1;
    aDev.sel <= 1'h1;
    aDev.io <= 1'h1;
    waitst(ST_SEL1);
    chk(rd[ST_WINNER_BIT], 1'h0);
    bDev.bsy <= 1'h1;
    aDev.bsy <= 1'h0;
    waitst(ST_SEL2);
    chk(rd[ST_RECONN_BIT], 1'h1);
    chk(dataDriveForce, 1'h0);
    savedBsy = aSideOeN.bsy;
    aDev.sel <= 1'h0;
    waitst(ST_XFER);
    chk(aSideOeN.bsy, !savedBsy);
    chk(dataDriveForce, 1'h1);
    aDev <= '0;
    bDev <= '0;
    cyc(20);
    aDev.rst <= 1'h1;
    cyc(5);
    chk({bSideOeN.rst, bSideOut.rst}, 2'h1);
    filteredClearIn <= 1'h1;
    cyc(4);
    apb(1'h0, ADDR_STATUS, 32'h0);
    filteredClearIn <= 1'h0;
    chk(rd[2:0], ST_BUS_FREE);
    chk(rd[ST_RSTDIR_LSB +: 2], RDIR_FROM_A);
    aDev.rst <= 1'h0;
    cyc(5);
    chk(bSideOeN.rst, 1'h1);
    bDev.rst <= 1'h1;
    cyc(5);
    chk(aSideOeN.rst, 1'h0);
    finish_test();
  end

  initial begin
    #50us;
    n_mismatch++;
    finish_test();
  end
endmodule : testbench
